// file: include/osl_pkg.sv
// constants and types of the oscillator select and lock block
package osl_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned ADDR_W        = 5;
    localparam int unsigned DATA_W        = 32;

    localparam logic [ADDR_W-1:0] OFS_CTRL      = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_TRIM_ADDR = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_TRIM_DATA = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 5'h0c;

    localparam logic [7:0] UNLOCK_KEY1 = 8'he7;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h18;
    localparam logic [7:0] CTRL_RST    = 8'h80;

    localparam int unsigned CTRL_RC_EN_BIT   = 7;
    localparam int unsigned CTRL_XTAL_EN_BIT = 6;
    localparam int unsigned CTRL_WDOG_EN_BIT = 5;
    localparam int unsigned SEL_W            = 3;

    localparam int unsigned STAT_LOCK_LSB   = 0;
    localparam int unsigned STAT_BUSY_BIT   = 3;
    localparam int unsigned STAT_RC_RDY_BIT = 4;
    localparam int unsigned STAT_SRC_LSB    = 5;

    localparam int unsigned TRIM_BYTES = 32;
    localparam int unsigned TRIM_AW    = 5;
    localparam logic [TRIM_AW-1:0] RC_TRIM_IDX = 5'h00;

    localparam int unsigned RC_FAST_HZ     = 5_530_000;
    localparam int unsigned RC_SLOW_HZ     = 32_800;
    localparam int unsigned RC_STARTUP_NS  = 25_000;
    localparam int unsigned RC_STARTUP_CYC =
        (RC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SWITCH_GAP_CYC = 4;

    typedef enum logic [SEL_W-1:0] {
        SRC_RC_FAST = 3'h0,
        SRC_RC_SLOW = 3'h1,
        SRC_XTAL    = 3'h2,
        SRC_EXT_RC  = 3'h3,
        SRC_EXT_PIN = 3'h4,
        SRC_WDOG    = 3'h5
    } osl_src_t;

    typedef enum logic [2:0] {
        LK_LOCKED = 3'b001,
        LK_HALF   = 3'b010,
        LK_OPEN   = 3'b100
    } osl_lock_t;

    typedef enum logic [2:0] {
        SW_RUN  = 3'b001,
        SW_STOP = 3'b010,
        SW_SWAP = 3'b100
    } osl_sw_t;
endpackage

// file: include/osl_trim_if.sv
// carrier between the control logic and the trim byte memory
`timescale 1ns/1ps
interface osl_trim_if #(
    parameter int unsigned AW = 5,
    parameter int unsigned DW = 8
);
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: rtl/osl_trim_mem.sv
// working copy of the trim bytes, registered read port
`timescale 1ns/1ps
module osl_trim_mem #(
    parameter int unsigned DEPTH = 32,
    parameter int unsigned AW    = 5,
    parameter int unsigned DW    = 8
) (
    input wire logic ref_clk,
    osl_trim_if.mem  t
);
    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rdata_r;

    if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_chk
        $error("trim memory depth does not fit its address width");
    end

    always_ff @(posedge ref_clk) begin
        if (t.we) begin
            mem[t.waddr] <= t.wdata;
        end
        rdata_r <= mem[t.raddr];
    end

    assign t.rdata = rdata_r;
endmodule

// file: rtl/osl_top.sv
// oscillator select, unlock sequence and trim access behind an Avalon-MM slave
`timescale 1ns/1ps
module osl_top #(
    parameter int unsigned SWITCH_GAP = osl_pkg::SWITCH_GAP_CYC
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic [osl_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [osl_pkg::DATA_W-1:0]  avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [osl_pkg::DATA_W-1:0]  avs_readdata,
    output logic                             avs_waitrequest,
    output logic      [osl_pkg::TRIM_AW-1:0] factory_addr,
    input  wire logic [7:0]                  factory_data,
    output logic                             rc_osc_en,
    output logic                             rc_osc_slow,
    output logic      [7:0]                  rc_osc_trim,
    output logic                             xtal_en,
    output logic                             watchdog_osc_en,
    output osl_pkg::osl_src_t                clk_src_sel,
    output logic                             clk_gate_en
);
    import osl_pkg::*;

    localparam int unsigned GAP_W = $clog2(SWITCH_GAP + 1);
    localparam int unsigned RDY_W = $clog2(RC_STARTUP_CYC + 1);

    if (SWITCH_GAP < 1 || SWITCH_GAP > 255) begin : g_chk
        $error("switch gap must be 1 to 255 cycles");
    end

    osl_trim_if #(.AW(TRIM_AW), .DW(8)) trim ();

    osl_trim_mem #(.DEPTH(TRIM_BYTES), .AW(TRIM_AW), .DW(8)) u_mem (
        .ref_clk (ref_clk),
        .t       (trim)
    );

    logic [7:0]         ctrl_r,      ctrl_nxt;
    osl_lock_t          lock_r,      lock_nxt;
    logic [TRIM_AW-1:0] taddr_r,     taddr_nxt;
    logic [7:0]         rc_trim_r,   rc_trim_nxt;
    logic               load_busy_r, load_busy_nxt;
    logic [TRIM_AW-1:0] load_cnt_r,  load_cnt_nxt;
    logic [1:0]         rd_cnt_r,    rd_cnt_nxt;
    logic [31:0]        rdata_r,     rdata_nxt;
    osl_sw_t            sw_r,        sw_nxt;
    osl_src_t           src_r,       src_nxt;
    logic [GAP_W-1:0]   gap_r,       gap_nxt;
    logic [RDY_W-1:0]   rdy_cnt_r,   rdy_cnt_nxt;
    logic               rc_rdy_r,    rc_rdy_nxt;

    logic               wr_acc;
    logic               wr_ctrl;
    logic [7:0]         wd;
    logic [31:0]        rd_mux;
    osl_src_t           target;

    // reads take two wait cycles so the registered trim read sees a fresh address
    assign avs_waitrequest = load_busy_r | (avs_read & (rd_cnt_r != 2'd2));
    assign wr_acc  = avs_write & ~avs_waitrequest & avs_byteenable[0];
    assign wd      = avs_writedata[7:0];
    assign wr_ctrl = wr_acc && (avs_address == OFS_CTRL);

    // unlock detector and control register
    always_comb begin
        lock_nxt = lock_r;
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            unique case (lock_r)
                LK_LOCKED: begin
                    if (wd == UNLOCK_KEY1) begin
                        lock_nxt = LK_HALF;
                    end
                end
                LK_HALF: begin
                    // a wrong value keeps the first key, only order matters
                    if (wd == UNLOCK_KEY2) begin
                        lock_nxt = LK_OPEN;
                    end
                end
                LK_OPEN: begin
                    ctrl_nxt = wd;
                    if (wd[SEL_W-1:0] > SRC_WDOG) begin
                        ctrl_nxt[SEL_W-1:0] = ctrl_r[SEL_W-1:0];
                    end
                    lock_nxt = LK_LOCKED;
                end
                default: begin
                    lock_nxt = LK_LOCKED;
                end
            endcase
        end
    end

    // trim access: factory image first, then software override
    always_comb begin
        trim.we       = load_busy_r | (wr_acc && (avs_address == OFS_TRIM_DATA));
        trim.waddr    = load_busy_r ? load_cnt_r : taddr_r;
        trim.wdata    = load_busy_r ? factory_data : wd;
        trim.raddr    = taddr_r;
        taddr_nxt     = taddr_r;
        if (wr_acc && (avs_address == OFS_TRIM_ADDR)) begin
            taddr_nxt = wd[TRIM_AW-1:0];
        end
        rc_trim_nxt   = rc_trim_r;
        if (trim.we && (trim.waddr == RC_TRIM_IDX)) begin
            rc_trim_nxt = trim.wdata;
        end
        load_cnt_nxt  = load_busy_r ? load_cnt_r + 1'b1 : load_cnt_r;
        load_busy_nxt = load_busy_r && (load_cnt_r != TRIM_AW'(TRIM_BYTES - 1));
    end

    // read path
    always_comb begin
        rd_mux = 32'h0;
        unique case (avs_address)
            OFS_CTRL:      rd_mux[7:0] = ctrl_r;
            OFS_TRIM_ADDR: rd_mux[TRIM_AW-1:0] = taddr_r;
            OFS_TRIM_DATA: rd_mux[7:0] = trim.rdata;
            OFS_STATUS: begin
                rd_mux[STAT_LOCK_LSB +: 3]     = lock_r;
                rd_mux[STAT_BUSY_BIT]          = (sw_r != SW_RUN);
                rd_mux[STAT_RC_RDY_BIT]        = rc_rdy_r;
                rd_mux[STAT_SRC_LSB +: SEL_W]  = src_r;
            end
            default:       rd_mux = 32'h0;
        endcase
        rd_cnt_nxt = 2'd0;
        if (avs_read && !load_busy_r && (rd_cnt_r != 2'd2)) begin
            rd_cnt_nxt = rd_cnt_r + 2'd1;
        end
        rdata_nxt = (rd_cnt_r == 2'd1) ? rd_mux : rdata_r;
    end

    // source switch: gate off, wait, change select, wait, gate on
    assign target = osl_src_t'(ctrl_r[SEL_W-1:0]);
    always_comb begin
        sw_nxt  = sw_r;
        src_nxt = src_r;
        gap_nxt = gap_r;
        unique case (sw_r)
            SW_RUN: begin
                if (target != src_r) begin
                    sw_nxt  = SW_STOP;
                    gap_nxt = '0;
                end
            end
            SW_STOP: begin
                gap_nxt = gap_r + 1'b1;
                if (gap_r == GAP_W'(SWITCH_GAP - 1)) begin
                    sw_nxt  = SW_SWAP;
                    src_nxt = target;
                    gap_nxt = '0;
                end
            end
            SW_SWAP: begin
                gap_nxt = gap_r + 1'b1;
                if (gap_r == GAP_W'(SWITCH_GAP - 1)) begin
                    sw_nxt = SW_RUN;
                end
            end
            default: begin
                sw_nxt = SW_RUN;
            end
        endcase
    end

    // start-up flag only for software polling; nothing here waits on it
    always_comb begin
        rdy_cnt_nxt = '0;
        rc_rdy_nxt  = 1'b0;
        if (ctrl_r[CTRL_RC_EN_BIT]) begin
            rdy_cnt_nxt = rc_rdy_r ? rdy_cnt_r : rdy_cnt_r + 1'b1;
            rc_rdy_nxt  = rc_rdy_r || (rdy_cnt_r == RDY_W'(RC_STARTUP_CYC - 1));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r      <= CTRL_RST;
            lock_r      <= LK_LOCKED;
            taddr_r     <= '0;
            rc_trim_r   <= '0;
            load_busy_r <= 1'b1;
            load_cnt_r  <= '0;
            rd_cnt_r    <= 2'd0;
            rdata_r     <= 32'h0;
            sw_r        <= SW_RUN;
            src_r       <= SRC_RC_FAST;
            gap_r       <= '0;
            rdy_cnt_r   <= '0;
            rc_rdy_r    <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            lock_r      <= lock_nxt;
            taddr_r     <= taddr_nxt;
            rc_trim_r   <= rc_trim_nxt;
            load_busy_r <= load_busy_nxt;
            load_cnt_r  <= load_cnt_nxt;
            rd_cnt_r    <= rd_cnt_nxt;
            rdata_r     <= rdata_nxt;
            sw_r        <= sw_nxt;
            src_r       <= src_nxt;
            gap_r       <= gap_nxt;
            rdy_cnt_r   <= rdy_cnt_nxt;
            rc_rdy_r    <= rc_rdy_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign factory_addr = load_cnt_r;
    // powering down the running source is allowed; software must avoid it
    assign rc_osc_en       = ctrl_r[CTRL_RC_EN_BIT];
    assign rc_osc_slow     = (src_r == SRC_RC_SLOW);
    assign rc_osc_trim     = rc_trim_r;
    assign xtal_en         = ctrl_r[CTRL_XTAL_EN_BIT];
    assign watchdog_osc_en = ctrl_r[CTRL_WDOG_EN_BIT];
    assign clk_src_sel  = src_r;
    assign clk_gate_en  = (sw_r == SW_RUN);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_key1;
        wr_ctrl && (lock_r == LK_LOCKED) && (wd == UNLOCK_KEY1);
    endsequence
    sequence s_key2;
        wr_ctrl && (lock_r == LK_HALF) && (wd == UNLOCK_KEY2);
    endsequence
    sequence s_load;
        wr_ctrl && (lock_r == LK_OPEN);
    endsequence

    property p_unlock_load;
        s_key2 |=> (lock_r == LK_OPEN);
    endproperty
    a_unlock_load: assert property (p_unlock_load)
        else $error("second key did not unlock");
    property p_open_load;
        s_load |=> (lock_r == LK_LOCKED) && (ctrl_r[7:SEL_W] == $past(wd[7:SEL_W]));
    endproperty
    a_open_load: assert property (p_open_load)
        else $error("unlocked write not loaded");
    property p_locked_ignore;
        (lock_r != LK_OPEN) |=> (ctrl_r == $past(ctrl_r));
    endproperty
    a_locked_ignore: assert property (p_locked_ignore)
        else $error("locked write changed control");
    // any value but the first key, the second one included, leaves it locked
    property p_key_order;
        wr_ctrl && (lock_r == LK_LOCKED) && (wd != UNLOCK_KEY1) |=> (lock_r == LK_LOCKED);
    endproperty
    a_key_order: assert property (p_key_order)
        else $error("key out of order moved unlock state");
    property p_half_hold;
        (lock_r == LK_HALF) && !(wr_ctrl && (wd == UNLOCK_KEY2)) |=> (lock_r == LK_HALF);
    endproperty
    a_half_hold: assert property (p_half_hold)
        else $error("first key lost");
    property p_other_regs;
        !wr_ctrl |=> (lock_r == $past(lock_r));
    endproperty
    a_other_regs: assert property (p_other_regs)
        else $error("other access moved unlock state");
    property p_reset_lock;
        disable iff (1'b0) rst |=> (lock_r == LK_LOCKED) && (ctrl_r == CTRL_RST);
    endproperty
    a_reset_lock: assert property (p_reset_lock)
        else $error("reset left unlock progress");
    // holds for a one-cycle gap as well: the select moves inside the gated stretch
    property p_gate_off;
        $changed(src_r) |-> !clk_gate_en && !$past(clk_gate_en);
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("source changed while clock gated on");
    property p_switch_done;
        $rose(sw_r == SW_STOP) |-> ##[1:600] clk_gate_en && (src_r == $past(target));
    endproperty
    a_switch_done: assert property (p_switch_done)
        else $error("switch did not complete");
    property p_trim_rc;
        trim.we && (trim.waddr == RC_TRIM_IDX) |=> (rc_osc_trim == $past(trim.wdata));
    endproperty
    a_trim_rc: assert property (p_trim_rc)
        else $error("oscillator trim not updated");
    property p_rc_off;
        !rc_osc_en |=> !rc_rdy_r;
    endproperty
    a_rc_off: assert property (p_rc_off)
        else $error("powered down oscillator flagged ready");
endmodule

// file: verif/osl_top_tb_top.sv
// self-checking bench for the oscillator select and lock block
`timescale 1ns/1ps
module osl_top_tb_top;
    import osl_pkg::*;
    localparam int unsigned GAP   = 2;
    localparam int unsigned LIMIT = 20000;

    logic                ref_clk;
    logic                rst;
    logic [ADDR_W-1:0]   avs_address;
    logic                avs_read;
    logic                avs_write;
    logic [DATA_W-1:0]   avs_writedata;
    logic [3:0]          avs_byteenable;
    logic [DATA_W-1:0]   avs_readdata;
    logic                avs_waitrequest;
    logic [TRIM_AW-1:0]  factory_addr;
    logic [7:0]          factory_data;
    logic                rc_osc_en;
    logic                rc_osc_slow;
    logic [7:0]          rc_osc_trim;
    logic                xtal_en;
    logic                watchdog_osc_en;
    osl_src_t            clk_src_sel;
    logic                clk_gate_en;
    logic [31:0]         q;
    logic [31:0]         junk;
    logic                prev_gate;
    osl_src_t            prev_src;
    int                  error_cnt;
    int                  total_checks;
    int                  cyc;

    function automatic logic [7:0] fac(input logic [4:0] a);
        return {a[2:0], a} ^ 8'h3c;
    endfunction

    // factory bytes answer in the same cycle as the index
    assign factory_data = fac(factory_addr);

    osl_top #(.SWITCH_GAP(GAP)) u_dut (
        .ref_clk         (ref_clk),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .factory_addr    (factory_addr),
        .factory_data    (factory_data),
        .rc_osc_en       (rc_osc_en),
        .rc_osc_slow     (rc_osc_slow),
        .rc_osc_trim     (rc_osc_trim),
        .xtal_en         (xtal_en),
        .watchdog_osc_en (watchdog_osc_en),
        .clk_src_sel     (clk_src_sel),
        .clk_gate_en     (clk_gate_en)
    );

    initial ref_clk = 1'b0;
    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // request held until the rising edge that samples waitrequest low;
    // data taken and request released at that same edge, the bench timeout ends a hang
    task automatic bus_xfer(input logic wr_n_rd, input logic [4:0] a, input logic [7:0] d,
                            input logic [3:0] be, output logic [31:0] rdat);
        @(posedge ref_clk);
        avs_address    <= a;
        avs_writedata  <= {24'h0, d};
        avs_byteenable <= be;
        avs_read       <= !wr_n_rd;
        avs_write      <= wr_n_rd;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        rdat = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus_xfer(1'b1, a, d, 4'h1, junk);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] rdat);
        bus_xfer(1'b0, a, 8'h00, 4'h1, rdat);
    endtask

    task automatic unlock_wr(input logic [7:0] v);
        wr(OFS_CTRL, UNLOCK_KEY1);
        wr(OFS_CTRL, UNLOCK_KEY2);
        wr(OFS_CTRL, v);
        @(negedge ref_clk);
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        // trim copy runs 32 cycles before the bus opens
        repeat (40) @(posedge ref_clk);
    endtask

    task automatic wait_gate();
        int n = 0;
        repeat (2) @(negedge ref_clk);
        while (clk_gate_en !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 100) check(32'h1, 32'h0, "clock gate stuck low");
    endtask

    // the source may only move while the system clock is gated
    always @(negedge ref_clk) begin
        if (!rst && prev_gate === 1'b1 && clk_src_sel !== prev_src) begin
            check(32'h1, 32'h0, "source moved while clock ran");
        end
        prev_gate <= clk_gate_en;
        prev_src  <= clk_src_sel;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial begin
        rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'h0;
        prev_gate = 1'b0;
        prev_src = SRC_RC_FAST;
        do_reset();
        rd(OFS_CTRL, q);
        check(q, {24'h0, CTRL_RST}, "ctrl after reset");
        rd(OFS_STATUS, q);
        check(32'(q[2:0]), 32'h1, "lock after reset");
        check(32'(rc_osc_trim), 32'(fac(5'h00)), "trim from factory");
        for (int i = 0; i < TRIM_BYTES; i++) begin
            wr(OFS_TRIM_ADDR, 8'(i));
            rd(OFS_TRIM_DATA, q);
            check(q, 32'(fac(5'(i))), "factory trim byte");
        end
        wr(OFS_TRIM_ADDR, 8'h00);
        wr(OFS_TRIM_DATA, 8'ha5);
        @(negedge ref_clk);
        check(32'(rc_osc_trim), 32'ha5, "trim override");
        wr(OFS_TRIM_ADDR, 8'h1f);
        wr(OFS_TRIM_DATA, 8'h5c);
        wr(5'h10, 8'h77);
        rd(5'h10, q);
        check(q, 32'h0, "unmapped read");
        bus_xfer(1'b1, OFS_TRIM_DATA, 8'h11, 4'h0, junk);
        rd(OFS_TRIM_DATA, q);
        check(q, 32'h5c, "last trim byte");
        wr(OFS_CTRL, 8'h00);
        rd(OFS_CTRL, q);
        check(q, 32'h80, "locked write ignored");
        wr(OFS_CTRL, UNLOCK_KEY1);
        rd(OFS_STATUS, q);
        check(32'(q[2:0]), 32'h2, "first key seen");
        wr(OFS_TRIM_ADDR, 8'h01);
        rd(OFS_TRIM_DATA, junk);
        wr(OFS_CTRL, 8'h33);
        rd(OFS_STATUS, q);
        check(32'(q[2:0]), 32'h2, "progress kept");
        wr(OFS_CTRL, UNLOCK_KEY2);
        rd(OFS_STATUS, q);
        check(32'(q[2:0]), 32'h4, "unlocked");
        wr(OFS_CTRL, 8'h98);
        rd(OFS_CTRL, q);
        check(q, 32'h98, "unlocked write loads");
        wr(OFS_CTRL, 8'h80);
        rd(OFS_CTRL, q);
        check(q, 32'h98, "relocked after load");
        for (int k = 1; k <= 6; k++) begin
            unlock_wr({5'b11100, 3'(k % 6)});
            wait_gate();
            rd(OFS_STATUS, q);
            check(32'(q[7:5]), 32'(k % 6), "status source");
            check(32'(clk_src_sel), 32'(k % 6), "selected source");
            check(32'(rc_osc_slow), 32'(k % 6 == 1), "slow mode");
            check(32'({xtal_en, watchdog_osc_en}), 32'h3, "enables");
        end
        unlock_wr(8'he6);
        rd(OFS_CTRL, q);
        check(q, 32'he0, "bad select kept");
        unlock_wr(8'h00);
        check(32'({rc_osc_en, xtal_en, watchdog_osc_en}), 32'h0, "oscillators off");
        unlock_wr(8'h80);
        rd(OFS_STATUS, q);
        check(32'(q[4]), 32'h0, "not ready yet");
        repeat (RC_STARTUP_CYC + 10) @(posedge ref_clk);
        rd(OFS_STATUS, q);
        check(32'(q[4]), 32'h1, "ready after start-up");
        wr(OFS_CTRL, UNLOCK_KEY1);
        wr(OFS_CTRL, UNLOCK_KEY2);
        do_reset();
        wr(OFS_CTRL, 8'h98);
        rd(OFS_CTRL, q);
        check(q, 32'h80, "unlock lost by reset");
        report_and_stop();
    end
endmodule
